// ---- hdl/vgm_regs.svh ----
/*
 Constants of the vector group phase matching block: register offsets,
 field positions, reset values and fixed-point figures.
 Assumes inclusion by bare name from the package; the modules use its macros through it.
*/
`ifndef VGM_REGS_SVH
`define VGM_REGS_SVH

// Register byte offsets
`define VGM_OFS_CTRL 12'h000
`define VGM_OFS_GROUP 12'h004
`define VGM_OFS_STATUS 12'h008
`define VGM_OFS_COUNT 12'h00C

// Control register fields
`define VGM_CTRL_ADV_BIT 0
`define VGM_CTRL_EARTHED_BIT 1
`define VGM_CTRL_HVZS_BIT 2
`define VGM_CTRL_REVROT_BIT 3
`define VGM_CTRL_LVZS_BIT 4
`define VGM_CTRL_TVZS_BIT 5
`define VGM_CTRL_RST 32'h0000_0000

// Group register fields: LV group in [3:0], tertiary group in [11:8]
`define VGM_GRP_LV_LSB 0
`define VGM_GRP_TV_LSB 8
`define VGM_GROUP_RST 32'h0000_0000

// Status fields
`define VGM_STAT_BUSY_BIT 0
`define VGM_STAT_FULL_BIT 1
`define VGM_STAT_BADGRP_BIT 2

// Angle step of one group unit in degrees, and the wrap of the clock face
`define VGM_STEP_DEG 30
`define VGM_FACE 12

// One over root three in Q1.17 (0.57735 * 131072)
`define VGM_INV_SQRT3 18'h12799
`define VGM_INV_SQRT3_FRAC 17
// One third in Q1.17 (131072 / 3)
`define VGM_ONE_THIRD 18'h0AAAB

`endif

// ---- hdl/vgm_pkg.sv ----
/*
 Types of the vector group phase matching block.
 Assumes vgm_regs.svh is on the include path.
*/
package vgm_pkg;
   `include "vgm_regs.svh"

   localparam int VGM_W = 24;

   typedef logic signed [VGM_W-1:0] vgm_val_t;

   typedef struct packed {
      vgm_val_t re;
      vgm_val_t im;
   } vgm_phasor_s;

   typedef struct packed {
      vgm_phasor_s a;
      vgm_phasor_s b;
      vgm_phasor_s c;
   } vgm_three_s;

   typedef struct packed {
      vgm_three_s hv;
      vgm_three_s lv;
      vgm_three_s tv;
   } vgm_sample_s;

   typedef enum logic [1:0] {
      VGM_IDLE = 2'b00,
      VGM_CALC = 2'b01,
      VGM_PUSH = 2'b10
   } vgm_state_e;
endpackage

// ---- hdl/vgm_rotate.sv ----
/*
 Rotates one three-phase current set by a clock-face group number, with
 optional zero-sequence removal. Purely combinational.
 Assumes the caller applies reverse rotation before giving the group.
*/
`timescale 1ns/1ps
`default_nettype none

module vgm_rotate
   import vgm_pkg::*;
(
   input wire vgm_three_s in_set,
   input wire logic [3:0] group_num,
   input wire logic zs_filter,
   input wire logic hv_mode,
   output vgm_three_s out_set,
   output logic bad_group
);
   localparam int P = 2 * VGM_W;
   localparam logic signed [17:0] K3 = `VGM_INV_SQRT3;
   localparam logic signed [17:0] K1 = `VGM_ONE_THIRD;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic vgm_val_t scale(input vgm_val_t v, input logic signed [17:0] k);
      logic signed [P-1:0] prod;
      prod = P'(v) * P'(k);
      scale = vgm_val_t'(prod >>> `VGM_INV_SQRT3_FRAC);
   endfunction

   vgm_val_t ph_re [3];
   vgm_val_t ph_im [3];
   vgm_val_t zs_re;
   vgm_val_t zs_im;
   vgm_val_t o_re [3];
   vgm_val_t o_im [3];

   assign ph_re[0] = in_set.a.re;
   assign ph_re[1] = in_set.b.re;
   assign ph_re[2] = in_set.c.re;
   assign ph_im[0] = in_set.a.im;
   assign ph_im[1] = in_set.b.im;
   assign ph_im[2] = in_set.c.im;

   // Zero sequence is the phase sum over three
   assign zs_re = scale(ph_re[0] + ph_re[1] + ph_re[2], K1);
   assign zs_im = scale(ph_im[0] + ph_im[1] + ph_im[2], K1);

   assign bad_group = (group_num > 4'hB);

   // ==========================================================
   // Per-phase operation
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_phase
         // Lagging phase is x+1, leading is x-1, wrapping over A, B, C
         localparam int LAG = (g + 1) % 3;
         localparam int LEAD = (g + 2) % 3;
         vgm_val_t sr;
         vgm_val_t si;
         vgm_val_t fr [3];
         vgm_val_t fi [3];
         always_comb begin
            for (int i = 0; i < 3; i++) begin
               fr[i] = zs_filter ? ph_re[i] - zs_re : ph_re[i];
               fi[i] = zs_filter ? ph_im[i] - zs_im : ph_im[i];
            end
            sr = '0;
            si = '0;
            if (hv_mode) begin
               sr = fr[g];
               si = fi[g];
            end else begin
               // Odd groups use raw currents: the difference drops zero sequence itself
               case (group_num)
                  4'h0: begin sr = fr[g]; si = fi[g]; end
                  4'h2: begin sr = -fr[LAG]; si = -fi[LAG]; end
                  4'h4: begin sr = fr[LEAD]; si = fi[LEAD]; end
                  4'h6: begin sr = -fr[g]; si = -fi[g]; end
                  4'h8: begin sr = fr[LAG]; si = fi[LAG]; end
                  4'hA: begin sr = -fr[LEAD]; si = -fi[LEAD]; end
                  4'h1: begin sr = scale(ph_re[g] - ph_re[LAG], K3); si = scale(ph_im[g] - ph_im[LAG], K3); end
                  4'h3: begin sr = scale(ph_re[LEAD] - ph_re[LAG], K3); si = scale(ph_im[LEAD] - ph_im[LAG], K3); end
                  4'h5: begin sr = scale(ph_re[LEAD] - ph_re[g], K3); si = scale(ph_im[LEAD] - ph_im[g], K3); end
                  4'h7: begin sr = scale(ph_re[LAG] - ph_re[g], K3); si = scale(ph_im[LAG] - ph_im[g], K3); end
                  4'h9: begin sr = scale(ph_re[LAG] - ph_re[LEAD], K3); si = scale(ph_im[LAG] - ph_im[LEAD], K3); end
                  4'hB: begin sr = scale(ph_re[g] - ph_re[LEAD], K3); si = scale(ph_im[g] - ph_im[LEAD], K3); end
                  default: begin sr = '0; si = '0; end
               endcase
            end
         end
         assign o_re[g] = sr;
         assign o_im[g] = si;
      end
   endgenerate

   assign out_set.a.re = o_re[0];
   assign out_set.a.im = o_im[0];
   assign out_set.b.re = o_re[1];
   assign out_set.b.im = o_im[1];
   assign out_set.c.re = o_re[2];
   assign out_set.c.im = o_im[2];
endmodule

`default_nettype wire

// ---- hdl/vgm_skid.sv ----
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module vgm_skid #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Head and spare entry are both registers, so the output side sees
   // flip-flops only and a stall loses no word
   initial begin
      if (DEPTH != 2) $error("vgm_skid serves only DEPTH of 2");
   end

   typedef struct packed {
      logic head_v;
      logic spare_v;
   } vgm_skid_s;

   vgm_skid_s st;
   vgm_skid_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   logic load_head;
   logic load_spare;

   assign in_ready = !st.spare_v;
   assign out_valid = st.head_v;
   assign out_data = mem[0];
   assign push = in_valid && in_ready;
   assign pop = st.head_v && out_ready;
   // The head refills when empty or leaving; otherwise the spare takes the word
   assign load_head = !st.head_v || pop;
   assign load_spare = push && !load_head;

   always_comb begin
      next_st = st;
      if (load_head) begin
         next_st.head_v = st.spare_v || push;
         next_st.spare_v = 1'b0;
      end else if (load_spare) begin
         next_st.spare_v = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge hclk) begin
      if (load_head && next_st.head_v) begin
         mem[0] <= st.spare_v ? mem[1] : in_data;
      end
      if (load_spare) begin
         mem[1] <= in_data;
      end
   end
endmodule

`default_nettype wire

// ---- hdl/vgm_top.sv ----
/*
 Vector group phase matching datapath with an AHB-Lite register slave.
 Takes amplitude-matched HV, LV and tertiary phasors with valid/ready,
 rotates LV and tertiary by their group numbers, filters zero sequence
 where set, and delivers the result through a two-entry buffer.
 Assumes a single AHB-Lite master, whole-word single transfers; hsize is
 not decoded. Assumes the upstream stage holds in_sample while in_valid
 stands, and that the receiver may stall for any time: a full buffer
 keeps the pipeline in its push state and in_ready low.
*/
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Group number counts thirty-degree LV lag steps
// - Only LV and tertiary currents are rotated
// - HV passes through, optionally zero-sequence filtered
// - HV filter: earthed in simple, enable in advanced
// - Zero sequence is phase sum divided by three
// - Filtered phase subtracts its own zero sequence
// - Odd groups remove zero sequence; even never automatically
// - x+1 lags, x-1 leads, wrapping A B C
// - Group 0 passes same phase
// - Group 2 negates lagging phase
// - Group 4 takes leading phase
// - Group 6 negates same phase
// - Group 8 takes lagging phase
// - Group 10 negates leading phase
// - Odd groups: phase difference over root three
// - Reverse rotation uses twelve minus group
module vgm_top
   import vgm_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic in_valid,
   output logic in_ready,
   input wire vgm_sample_s in_sample,
   output logic out_valid,
   input wire logic out_ready,
   output vgm_sample_s out_sample
);
   localparam int SW = $bits(vgm_sample_s);
   // Writable bits of the control and group registers
   localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
   localparam logic [31:0] GROUP_MASK = 32'h0000_0F0F;

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   initial begin
      if (BUF_DEPTH != 2) $error("vgm_top serves only a two-entry buffer");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] group;
      logic [31:0] count;
      logic [31:0] rdata;
      logic ap_write;
      logic [11:0] ap_addr;
      vgm_state_e fsm;
      vgm_sample_s hold;
      vgm_sample_s res;
      logic res_valid;
      logic bad_grp;
      logic in_rdy;
   } vgm_top_s;

   vgm_top_s st;
   vgm_top_s next_st;

   logic take_ap;
   logic hv_zs;
   logic [3:0] lv_grp_raw;
   logic [3:0] tv_grp_raw;
   logic [3:0] lv_grp;
   logic [3:0] tv_grp;
   vgm_three_s hv_out;
   vgm_three_s lv_out;
   vgm_three_s tv_out;
   logic hv_bad;
   logic lv_bad;
   logic tv_bad;
   logic buf_in_ready;
   logic buf_out_valid;
   vgm_sample_s buf_out_data;
   logic [31:0] status_word;

   // ==========================================================
   // Bus and configuration decode
   // ==========================================================
   // An address phase is taken only when the bus is ready
   assign take_ap = hsel && hready && htrans[1];

   // HV filtering source depends on mode
   assign hv_zs = st.ctrl[`VGM_CTRL_ADV_BIT] ? st.ctrl[`VGM_CTRL_HVZS_BIT]
                                             : st.ctrl[`VGM_CTRL_EARTHED_BIT];

   // ==========================================================
   // Group decode
   // ==========================================================
   assign lv_grp_raw = st.group[`VGM_GRP_LV_LSB +: 4];
   assign tv_grp_raw = st.group[`VGM_GRP_TV_LSB +: 4];

   // Reverse sequence maps group g to 12-g, with 0 staying 0
   function automatic logic [3:0] eff_group(input logic [3:0] g, input logic rev);
      logic [3:0] face;
      face = 4'(`VGM_FACE);
      // Groups above eleven pass unchanged; the rotator flags them
      if (rev && g != 4'h0 && g <= 4'hB) eff_group = face - g;
      else eff_group = g;
   endfunction

   // Group number is a clock-face count of thirty-degree steps
   assign lv_grp = eff_group(lv_grp_raw, st.ctrl[`VGM_CTRL_REVROT_BIT]);
   assign tv_grp = eff_group(tv_grp_raw, st.ctrl[`VGM_CTRL_REVROT_BIT]);

   // ==========================================================
   // Datapath
   // ==========================================================
   // HV is the reference: group zero, never rotated
   vgm_rotate u_hv (
      .in_set(st.hold.hv),
      .group_num(4'h0),
      .zs_filter(hv_zs),
      .hv_mode(1'b1),
      .out_set(hv_out),
      .bad_group(hv_bad)
   );

   // Only LV and tertiary sets see rotation
   vgm_rotate u_lv (
      .in_set(st.hold.lv),
      .group_num(lv_grp),
      .zs_filter(st.ctrl[`VGM_CTRL_LVZS_BIT]),
      .hv_mode(1'b0),
      .out_set(lv_out),
      .bad_group(lv_bad)
   );

   vgm_rotate u_tv (
      .in_set(st.hold.tv),
      .group_num(tv_grp),
      .zs_filter(st.ctrl[`VGM_CTRL_TVZS_BIT]),
      .hv_mode(1'b0),
      .out_set(tv_out),
      .bad_group(tv_bad)
   );

   // Two-entry buffer: a stall by the receiver loses no result
   vgm_skid #(
      .WIDTH(SW),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_valid(st.res_valid),
      .in_ready(buf_in_ready),
      .in_data(st.res),
      .out_valid(buf_out_valid),
      .out_ready(out_ready),
      .out_data(buf_out_data)
   );

   // ==========================================================
   // Status
   // ==========================================================
   // Full means both buffer entries hold a result
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`VGM_STAT_BUSY_BIT] = (st.fsm != VGM_IDLE);
      status_word[`VGM_STAT_FULL_BIT] = !buf_in_ready;
      status_word[`VGM_STAT_BADGRP_BIT] = st.bad_grp;
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_st = st;

      // Bus address phase capture
      next_st.ap_write = take_ap && hwrite;
      if (take_ap) next_st.ap_addr = haddr;

      // Data phase write
      if (st.ap_write) begin
         case (st.ap_addr)
            `VGM_OFS_CTRL: begin
               next_st.ctrl = hwdata & CTRL_MASK;
            end
            `VGM_OFS_GROUP: begin
               next_st.group = hwdata & GROUP_MASK;
            end
            // Any write clears the delivered count, unless a push completes in the same cycle: then the increment wins
            `VGM_OFS_COUNT: begin
               next_st.count = 32'h0000_0000;
            end
            // Status is read only; unmapped offsets ignore writes
            default: ;
         endcase
      end

      // Read data registered at the address phase; a write in its data phase
      // is forwarded so that a pipelined read right behind it sees the new word
      if (take_ap && !hwrite) begin
         case (haddr)
            `VGM_OFS_CTRL: begin
               next_st.rdata = next_st.ctrl;
            end
            `VGM_OFS_GROUP: begin
               next_st.rdata = next_st.group;
            end
            `VGM_OFS_STATUS: begin
               next_st.rdata = status_word;
            end
            `VGM_OFS_COUNT: begin
               next_st.rdata = next_st.count;
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Sample pipeline: take, compute, push into the buffer
      next_st.res_valid = 1'b0;
      case (st.fsm)
         VGM_IDLE: begin
            // Capture one sample when idle
            if (in_valid) begin
               next_st.hold = in_sample;
               next_st.fsm = VGM_CALC;
            end
         end
         VGM_CALC: begin
            // All three sets of one update leave together
            next_st.res.hv = hv_out;
            next_st.res.lv = lv_out;
            next_st.res.tv = tv_out;
            // Flag any group above eleven for the status word
            next_st.bad_grp = hv_bad | lv_bad | tv_bad;
            next_st.fsm = VGM_PUSH;
         end
         VGM_PUSH: begin
            // Offer the result until the buffer takes it
            next_st.res_valid = 1'b1;
            if (st.res_valid && buf_in_ready) begin
               next_st.res_valid = 1'b0;
               next_st.count = st.count + 32'h0000_0001;
               next_st.fsm = VGM_IDLE;
            end
         end
         default: next_st.fsm = VGM_IDLE;
      endcase

      // Ready is a register loaded from the next state, so it is high exactly while the state is idle
      next_st.in_rdy = (next_st.fsm == VGM_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.ctrl <= `VGM_CTRL_RST;
         st.group <= `VGM_GROUP_RST;
         st.fsm <= VGM_IDLE;
         st.in_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Read data, ready and the buffer head are registers; hreadyout and hresp are tied constants
   assign hrdata = st.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign in_ready = st.in_rdy;
   assign out_valid = buf_out_valid;
   assign out_sample = buf_out_data;
endmodule

`default_nettype wire

// ---- tb/vgm_top_assertions.sv ----
/*
 Checker of the vgm_top ports, bound to the design top.
 Assumes one AHB-Lite master doing whole-word single transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module vgm_top_assertions
   import vgm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire vgm_sample_s out_sample
);
   // ==========================================
   // Bus tracking
   logic ap_v;
   logic ap_w;
   logic [11:0] ap_a;
   logic [5:0] ctrl_q;
   logic [11:0] grp_q;
   wire logic take;
   assign take = in_valid && in_ready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v <= 1'b0;
         ap_w <= 1'b0;
         ap_a <= 12'h000;
         ctrl_q <= 6'h00;
         grp_q <= 12'h000;
      end else begin
         ap_v <= hsel && hready && htrans[1];
         ap_w <= hwrite;
         ap_a <= haddr;
         if (ap_v && ap_w && ap_a == 12'h000) ctrl_q <= hwdata[5:0];
         if (ap_v && ap_w && ap_a == 12'h004) grp_q <= hwdata[11:0] & 12'hF0F;
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_zero_wait: assert property (hreadyout == 1'b1)
      else $error("wait state inserted");
   chk_busy_after_take: assert property (take |=> !in_ready [*2])
      else $error("sample taken while busy");
   chk_first_result: assert property (take && !out_valid |-> ##[1:6] out_valid)
      else $error("result late");
   chk_head_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
      else $error("result dropped during stall");
   chk_unmapped_zero: assert property (ap_v && !ap_w && ap_a >= 12'h010 |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (ap_v && !ap_w && ap_a == 12'h000 |-> hrdata[5:0] == ctrl_q)
      else $error("control readback wrong");
   chk_group_readback: assert property (ap_v && !ap_w && ap_a == 12'h004 |-> (hrdata[11:0] & 12'hF0F) == grp_q)
      else $error("group readback wrong");
endmodule
bind vgm_top vgm_top_assertions vgm_top_assertions_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
   .out_ready(out_ready), .out_sample(out_sample));
`default_nettype wire

// ---- tb/vgm_diff_sink.sv ----
/*
 Model of the differential stage taking matched samples.
 Assumes the bench drives stall to hold it back.
*/
`timescale 1ns/1ps
`default_nettype none
module vgm_diff_sink
   import vgm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic out_valid,
   output logic out_ready,
   input wire vgm_sample_s out_sample,
   input wire logic stall,
   output int n_got
);
   vgm_sample_s got_q [0:255];
   // ==========================================
   // Whole samples taken in arrival order
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_ready <= 1'b0;
         n_got <= 0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) begin
            got_q[n_got[7:0]] <= out_sample;
            n_got <= n_got + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/vgm_top_tb.sv ----
/*
 Self-checking bench of vgm_top with a model of the receiving stage.
 Assumes vgm_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module vgm_top_tb;
   import vgm_pkg::*;
   localparam int SW = $bits(vgm_sample_s);
   localparam longint K3 = 64'h0AAAB;
   localparam longint KR = 64'h12799;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, in_valid = 1'b0, stall = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, in_ready, out_valid, out_ready;
   wire logic hready;
   vgm_sample_s in_sample = '0, out_sample, exp_q [0:127];
   int n_mismatch = 0, checks_done = 0, cyc = 0, n_sent = 0, n_chk = 0, n_got;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   vgm_top vgm_top_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_ready(in_ready),
      .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample));
   vgm_diff_sink vgm_diff_sink_inst(.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
      .out_ready(out_ready), .out_sample(out_sample), .stall(stall), .n_got(n_got));
   // ==========================================
   // Helpers
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [SW-1:0] seen, input logic [SW-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   function automatic vgm_val_t rot(input vgm_val_t p [3], input int x, input int g, input bit f);
      longint k, v;
      int lag, lead;
      lag = (x + 1) % 3;
      lead = (x + 2) % 3;
      k = f ? (((longint'(p[0]) + p[1] + p[2]) * K3) >>> 17) : 0;
      case (g)
         0: v = p[x] - k;
         2: v = k - p[lag];
         4: v = p[lead] - k;
         6: v = k - p[x];
         8: v = p[lag] - k;
         10: v = k - p[lead];
         1: v = ((longint'(p[x]) - p[lag]) * KR) >>> 17;
         3: v = ((longint'(p[lead]) - p[lag]) * KR) >>> 17;
         5: v = ((longint'(p[lead]) - p[x]) * KR) >>> 17;
         7: v = ((longint'(p[lag]) - p[x]) * KR) >>> 17;
         9: v = ((longint'(p[lag]) - p[lead]) * KR) >>> 17;
         11: v = ((longint'(p[x]) - p[lead]) * KR) >>> 17;
         default: v = 0;
      endcase
      return vgm_val_t'(v);
   endfunction
   function automatic vgm_three_s exp3(input vgm_three_s s, input int g, input bit f);
      vgm_phasor_s q [3];
      vgm_val_t r [3], m [3];
      q = '{s.a, s.b, s.c};
      for (int i = 0; i < 3; i++) begin
         r[i] = q[i].re;
         m[i] = q[i].im;
      end
      for (int i = 0; i < 3; i++) begin
         q[i].re = rot(r, i, g, f);
         q[i].im = rot(m, i, g, f);
      end
      return '{q[0], q[1], q[2]};
   endfunction
   function automatic vgm_sample_s mk(input int k);
      vgm_phasor_s p [9];
      for (int i = 0; i < 9; i++) begin
         p[i].re = vgm_val_t'(1000 * i - 3000 + 37 * k);
         p[i].im = vgm_val_t'(500 - 211 * i + k);
      end
      return '{'{p[0], p[1], p[2]}, '{p[3], p[4], p[5]}, '{p[6], p[7], p[8]}};
   endfunction
   task automatic push(input vgm_sample_s s, input vgm_sample_s e);
      in_sample <= s;
      in_valid <= 1'b1;
      @(negedge hclk);
      while (in_ready !== 1'b1) @(negedge hclk);
      @(posedge hclk);
      in_valid <= 1'b0;
      exp_q[n_sent] = e;
      n_sent++;
      @(posedge hclk);
   endtask
   task automatic drain;
      for (int i = 0; i < 60 && n_got < n_sent; i++) @(posedge hclk);
      for (int j = n_chk; j < n_sent; j++) check(vgm_diff_sink_inst.got_q[j], exp_q[j]);
      n_chk = n_sent;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      bus(12'h000, 1'b0, 32'h0);
      check(SW'(rd), SW'(32'h0));
      bus(12'h004, 1'b0, 32'h0);
      check(SW'(rd), SW'(32'h0));
      bus(12'h010, 1'b1, 32'hA5A5_A5A5);
      bus(12'h010, 1'b0, 32'h0);
      check(SW'(rd), SW'(32'h0));
      bus(12'h000, 1'b1, 32'h0000_003F);
      bus(12'h000, 1'b0, 32'h0);
      check(SW'(rd[5:0]), SW'(6'h3F));
      $display("test regs done");
   endtask
   task automatic t_hv;
      vgm_sample_s s, e;
      bus(12'h004, 1'b1, 32'h0);
      for (int m = 0; m < 8; m++) begin
         bus(12'h000, 1'b1, 32'(m));
         s = mk(m);
         e = s;
         e.hv = exp3(s.hv, 0, m[0] ? m[2] : m[1]);
         push(s, e);
         drain();
      end
      $display("test hv done");
   endtask
   task automatic t_groups;
      vgm_sample_s s, e;
      int ge;
      for (int rv = 0; rv < 2; rv++) begin
         for (int g = 0; g < (rv ? 12 : 16); g++) begin
            for (int f = 0; f < 2; f++) begin
               bus(12'h000, 1'b1, {26'h0, f == 0, f == 1, rv == 1, 3'b000});
               bus(12'h004, 1'b1, {20'h0, 4'(g), 4'h0, 4'(g)});
               ge = (rv == 1 && g != 0) ? 12 - g : g;
               s = mk(g + 16 * f);
               e = s;
               e.lv = exp3(s.lv, ge, f == 1);
               e.tv = exp3(s.tv, ge, f == 0);
               push(s, e);
               drain();
               if (rv == 0) begin
                  bus(12'h008, 1'b0, 32'h0);
                  check(SW'(rd[2]), SW'(g > 11));
               end
            end
         end
      end
      $display("test groups done");
   endtask
   task automatic t_stall;
      bus(12'h000, 1'b0, 32'h0);
      bus(12'h000, 1'b1, 32'h0);
      bus(12'h004, 1'b1, 32'h0);
      stall <= 1'b1;
      for (int k = 0; k < 3; k++) push(mk(40 + k), mk(40 + k));
      repeat (6) @(posedge hclk);
      check(SW'(in_ready), SW'(1'b0));
      bus(12'h008, 1'b0, 32'h0);
      check(SW'(rd[1]), SW'(1'b1));
      stall <= 1'b0;
      drain();
      bus(12'h00C, 1'b0, 32'h0);
      check(SW'(rd), SW'(n_sent));
      bus(12'h00C, 1'b1, 32'h0);
      bus(12'h00C, 1'b0, 32'h0);
      check(SW'(rd), SW'(32'h0));
      $display("test stall done");
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_hv();
      t_groups();
      t_stall();
      tally_and_finish();
   end
endmodule
`default_nettype wire
